// file: dv/brd_bplane_model.sv
// backplane reset line seen by this board, with other boards on it
// assumes open-drain drive from the design and a pull-up on the line
`timescale 1ns/1ps
module brd_bplane_model (
  // drive from this board
  input wire logic sysreset_out,
  input wire logic sysreset_oe_n,
  // another board pulling the line, active low
  input wire logic other_drive_n,
  // resolved line
  output logic line_n
);
  // -----------------------------------------------
  // wired-and with pull-up
  // -----------------------------------------------
  assign line_n = ((!sysreset_oe_n && !sysreset_out) || !other_drive_n) ? 1'b0 : 1'b1;
endmodule

// file: dv/tb.sv
// self-checking bench for the board reset distribution
// assumes hold stretch of one cycle; backplane line resolved by brd_bplane_model
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] req_n = 8'hff;
  logic sys_controller = 1'b0;
  logic sysreset_in_n;
  logic sysreset_out;
  logic sysreset_oe_n;
  wire [4:0] dom_n;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [31:0] seed = 32'hcc290556;
  logic [6:0] prev;

  always #12.5 mclk = ~mclk;

  brd_reset_dist #(.HOLD_CYCLES(1)) brd_reset_dist_inst (
    .mclk(mclk), .rst_n(rst_n),
    .por_n(req_n[0]), .reset_switch_n(req_n[1]), .watchdog_n(req_n[2]),
    .alternate_hot_reset_n(req_n[3]), .io_reset_n(req_n[4]),
    .sys_sw_reset_n(req_n[5]), .local_sw_reset_n(req_n[6]),
    .sysreset_in_n(sysreset_in_n), .sysreset_out(sysreset_out),
    .sysreset_oe_n(sysreset_oe_n), .sys_controller(sys_controller),
    .cpu_reset_n(dom_n[0]), .bridge_reset_n(dom_n[1]), .memctl_reset_n(dom_n[2]),
    .pci_reset_n(dom_n[3]), .isa_reset_n(dom_n[4])
  );

  brd_bplane_model brd_bplane_model_inst (
    .sysreset_out(sysreset_out), .sysreset_oe_n(sysreset_oe_n),
    .other_drive_n(req_n[7]), .line_n(sysreset_in_n)
  );

  // -----------------------------------------------
  // reference model: bit set = request active
  // -----------------------------------------------
  function automatic logic [6:0] ref_out(int req, int sc);
    int board;
    int drive;
    board = (req & 32'hef) != 0;
    drive = (sc != 0) && ((req & 32'h2f) != 0);
    ref_out[2:0] = board ? 3'h0 : 3'h7;
    ref_out[4:3] = (board || (req & 32'h10) != 0) ? 2'h0 : 2'h3;
    ref_out[5] = !drive;
    ref_out[6] = 1'b0;
  endfunction

  function automatic logic [31:0] lfsr(logic [31:0] s);
    lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(logic [6:0] got, logic [6:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %b expected %b", $time, got, exp);
    end
  endtask

  // apply a request set, check no on-board domain released early, then settled value
  task automatic apply(int req, int sc);
    logic [6:0] now;
    @(posedge mclk);
    req_n <= ~req[7:0];
    sys_controller <= sc[0];
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    now = {sysreset_out, sysreset_oe_n, dom_n};
    check({2'h0, now[4:0] & ~prev[4:0]}, 7'h0);
    repeat (13) @(posedge mclk);
    @(negedge mclk);
    prev = {sysreset_out, sysreset_oe_n, dom_n};
    check(prev, ref_out(req, sc));
  endtask

  // -----------------------------------------------
  // hang guard
  // -----------------------------------------------
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    int r;
    prev = 7'h7f;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    apply(0, 0);
    // every source alone, both board roles
    for (int s = 0; s < 8; s++) begin
      for (int sc = 0; sc < 2; sc++) begin
        apply(1 << s, sc);
        apply(0, sc);
      end
    end
    // overlapping random sets
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      r = int'(seed[7:0] & seed[15:8]);
      apply(r, int'(seed[16]));
    end
    // mid-run reset: reset values, then power-on release again
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    check({sysreset_out, sysreset_oe_n, dom_n}, 7'h20);
    @(posedge mclk);
    rst_n <= 1'b1;
    prev = 7'h7f;
    apply(0, 0);
    wrap_up();
  end
endmodule

// file: hdl/brd_reset_dist.sv
// board reset distribution: gathers reset requests, drives each domain
// assumes all request pins are asynchronous and active low; the backplane
// line is open drain, resolved outside from sysreset_oe_n
//
// Overview of operation
// - power-on resets every on-board domain, and backplane when system controller
// - front-panel switch resets all on-board domains, backplane only as system controller
// - watchdog timeout resets all on-board domains, backplane when system controller
// - alternate hot reset resets on-board domains; backplane per source list choice
// - io reset touches only pci and isa domains, never processor, bridge, memory
// - system software reset resets on-board domains and backplane as system controller
// - local software reset resets on-board domains, never drives backplane reset
`timescale 1ns/1ps
module brd_reset_dist #(
  parameter int HOLD_CYCLES = brd_pkg::RELEASE_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // reset requests
  input wire logic por_n,
  input wire logic reset_switch_n,
  input wire logic watchdog_n,
  input wire logic alternate_hot_reset_n,
  input wire logic io_reset_n,
  input wire logic sys_sw_reset_n,
  input wire logic local_sw_reset_n,
  // backplane system reset, open drain
  input wire logic sysreset_in_n,
  output logic sysreset_out,
  output logic sysreset_oe_n,
  // board role strap
  input wire logic sys_controller,
  // domain resets
  output logic cpu_reset_n,
  output logic bridge_reset_n,
  output logic memctl_reset_n,
  output logic pci_reset_n,
  output logic isa_reset_n
);
  import brd_pkg::*;

  // release stretch must fit the hold counter
  if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (1 << HOLD_CNT_W)) begin : g_bad_hold
    $error("brd_reset_dist: HOLD_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [NUM_IN-1:0] pin_raw;
  logic [NUM_IN-1:0] sync_1;
  logic [NUM_IN-1:0] sync_2;

  assign pin_raw[IN_POR] = por_n;
  assign pin_raw[IN_SWITCH] = reset_switch_n;
  assign pin_raw[IN_WDOG] = watchdog_n;
  assign pin_raw[IN_HOT] = alternate_hot_reset_n;
  assign pin_raw[IN_IO] = io_reset_n;
  assign pin_raw[IN_BPLANE] = sysreset_in_n;
  assign pin_raw[IN_SYSSW] = sys_sw_reset_n;
  assign pin_raw[IN_LOCSW] = local_sw_reset_n;
  // strap is active high; invert so every bit idles high
  assign pin_raw[IN_SYSCTL] = ~sys_controller;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_1 <= SYNC_RESET;
      sync_2 <= SYNC_RESET;
    end else begin
      sync_1 <= pin_raw;
      sync_2 <= sync_1;
    end
  end

  // ----------------------------------------------------------------
  // active-high requests
  // ----------------------------------------------------------------
  logic [NUM_IN-1:0] req;
  logic board_req;
  logic io_req;
  logic vme_src;
  logic [NUM_DOM-1:0] dom_req;
  logic [NUM_DOM-1:0] dom_rst_n;

  assign req = ~sync_2;

  // every source that resets the whole board
  assign board_req = req[IN_POR]
                   | req[IN_SWITCH]
                   | req[IN_WDOG]
                   | req[IN_HOT]
                   | req[IN_BPLANE]
                   | req[IN_SYSSW]
                   | req[IN_LOCSW];

  assign io_req = req[IN_IO];

  // sources that drive the backplane; incoming line excluded so our own
  // drive can never latch itself on
  assign vme_src = req[IN_POR]
                 | req[IN_SWITCH]
                 | req[IN_WDOG]
                 | (HOT_TO_BACKPLANE & req[IN_HOT])
                 | req[IN_SYSSW];

  // ----------------------------------------------------------------
  // domain request map
  // ----------------------------------------------------------------
  always_comb begin
    dom_req = '0;
    dom_req[DOM_CPU] = board_req;
    dom_req[DOM_BRIDGE] = board_req;
    dom_req[DOM_MEM] = board_req;
    dom_req[DOM_PCI] = board_req | io_req;
    dom_req[DOM_ISA] = board_req | io_req;
    dom_req[DOM_VME] = req[IN_SYSCTL] & vme_src;
  end

  // ----------------------------------------------------------------
  // per-domain hold stages
  // ----------------------------------------------------------------
  for (genvar d = 0; d < NUM_DOM; d++) begin : g_dom
    brd_rst_hold #(
      .HOLD_CYCLES(HOLD_CYCLES),
      .RESET_N_VALUE(DOM_RESET_N[d])
    ) u_hold (
      .mclk(mclk),
      .rst_n(rst_n),
      .req(dom_req[d]),
      .rst_out_n(dom_rst_n[d])
    );
  end

  assign cpu_reset_n = dom_rst_n[DOM_CPU];
  assign bridge_reset_n = dom_rst_n[DOM_BRIDGE];
  assign memctl_reset_n = dom_rst_n[DOM_MEM];
  assign pci_reset_n = dom_rst_n[DOM_PCI];
  assign isa_reset_n = dom_rst_n[DOM_ISA];
  // low enable means pulling the backplane line low
  assign sysreset_oe_n = dom_rst_n[DOM_VME];

  // open-drain level is always low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sysreset_out <= 1'b0;
    end else begin
      sysreset_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_por_board: assert property (
    @(posedge mclk) disable iff (!rst_n)
    req[IN_POR] |=> !cpu_reset_n && !bridge_reset_n && !memctl_reset_n
                    && !pci_reset_n && !isa_reset_n)
    else $error("power-on did not reset every on-board domain");

  a_por_backplane: assert property (
    @(posedge mclk) disable iff (!rst_n)
    req[IN_POR] && req[IN_SYSCTL] |=> !sysreset_oe_n)
    else $error("power-on did not drive backplane as system controller");

  a_switch_reset: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $rose(req[IN_SWITCH]) && req[IN_SYSCTL]
      |=> !cpu_reset_n && !isa_reset_n && !sysreset_oe_n)
    else $error("switch did not reset board and backplane");

  a_switch_slave: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !req[IN_SYSCTL] && sysreset_oe_n |=> sysreset_oe_n)
    else $error("backplane driven while not system controller");

  a_wdog_reset: assert property (
    @(posedge mclk) disable iff (!rst_n)
    req[IN_WDOG] |=> !memctl_reset_n && !pci_reset_n
                     && (sysreset_oe_n == !$past(req[IN_SYSCTL]) || !sysreset_oe_n))
    else $error("watchdog reset missing");

  a_hot_reset: assert property (
    @(posedge mclk) disable iff (!rst_n)
    req[IN_HOT] |=> !cpu_reset_n && !bridge_reset_n && !memctl_reset_n
                    && !pci_reset_n && !isa_reset_n)
    else $error("alternate hot reset did not reset board");

  a_io_local: assert property (
    @(posedge mclk) disable iff (!rst_n)
    req[IN_IO] |=> !pci_reset_n && !isa_reset_n)
    else $error("io reset did not reach pci and isa");

  a_io_spares_cpu: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !board_req && cpu_reset_n && bridge_reset_n |=> cpu_reset_n && bridge_reset_n)
    else $error("processor or bridge reset without a board source");

  a_bplane_in: assert property (
    @(posedge mclk) disable iff (!rst_n)
    req[IN_BPLANE] |=> !cpu_reset_n && !memctl_reset_n && !isa_reset_n)
    else $error("incoming backplane reset ignored");

  a_syssw_prop: assert property (
    @(posedge mclk) disable iff (!rst_n)
    req[IN_SYSSW] && req[IN_SYSCTL] |=> !sysreset_oe_n && !bridge_reset_n)
    else $error("system software reset not propagated");

  a_locsw_local: assert property (
    @(posedge mclk) disable iff (!rst_n)
    req[IN_LOCSW] && !vme_src && sysreset_oe_n |=> sysreset_oe_n ##0 !cpu_reset_n)
    else $error("local software reset wrong");

  a_hold_board: assert property (
    @(posedge mclk) disable iff (!rst_n)
    board_req ##1 !board_req |-> !cpu_reset_n ##1 !cpu_reset_n)
    else $error("processor reset released before stretch");

  a_bplane_no_echo: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !vme_src && sysreset_oe_n |=> sysreset_oe_n)
    else $error("backplane driven without a driving source");

endmodule

// file: hdl/brd_rst_hold.sv
// one reset domain output with a release stretch
// assumes req is a same-clock level from the distribution logic
`timescale 1ns/1ps
module brd_rst_hold #(
  parameter int HOLD_CYCLES = brd_pkg::RELEASE_CYCLES,
  parameter logic RESET_N_VALUE = 1'b0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // request and reset out
  input wire logic req,
  output logic rst_out_n
);
  import brd_pkg::*;

  localparam logic [HOLD_CNT_W-1:0] HOLD_MAX = HOLD_CNT_W'(HOLD_CYCLES);

  logic [HOLD_CNT_W-1:0] cnt;

  if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (1 << HOLD_CNT_W)) begin : g_bad_hold
    $error("brd_rst_hold: HOLD_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // assert at once, release only after the request has been quiet
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      rst_out_n <= RESET_N_VALUE;
    end else if (req) begin
      cnt <= '0;
      rst_out_n <= 1'b0;
    end else if (cnt < HOLD_MAX) begin
      cnt <= cnt + 1'b1;
    end else begin
      rst_out_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_hold_assert: assert property (
    @(posedge mclk) disable iff (!rst_n) req |=> !rst_out_n)
    else $error("reset not asserted after request");

  a_hold_stretch: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $fell(req) |-> !rst_out_n ##1 !rst_out_n)
    else $error("reset released too early after request dropped");

  a_hold_release: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!req && !rst_out_n && cnt == HOLD_MAX) |=> rst_out_n || req)
    else $error("reset not released after stretch");

endmodule

// file: include/brd_pkg.sv
// board reset distribution: shared indices, reset values and timing counts
// assumes a single 40 MHz clock; all request pins are active low
package brd_pkg;

  // ----------------------------------------------------------------
  // clock and release timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int RELEASE_TIME_NS = 100;
  // least time, so round up to whole cycles
  localparam int RELEASE_CYCLES = (RELEASE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_CNT_W = 8;

  // ----------------------------------------------------------------
  // synchronised input vector, bit positions
  // ----------------------------------------------------------------
  localparam int NUM_IN = 9;
  localparam int IN_POR = 0;
  localparam int IN_SWITCH = 1;
  localparam int IN_WDOG = 2;
  localparam int IN_HOT = 3;
  localparam int IN_IO = 4;
  localparam int IN_BPLANE = 5;
  localparam int IN_SYSSW = 6;
  localparam int IN_LOCSW = 7;
  localparam int IN_SYSCTL = 8;
  // power-on reads as pending, every other request idle, not system controller
  localparam logic [NUM_IN-1:0] SYNC_RESET = 9'h1fe;

  // ----------------------------------------------------------------
  // reset domains
  // ----------------------------------------------------------------
  localparam int NUM_DOM = 6;
  localparam int DOM_CPU = 0;
  localparam int DOM_BRIDGE = 1;
  localparam int DOM_MEM = 2;
  localparam int DOM_PCI = 3;
  localparam int DOM_ISA = 4;
  localparam int DOM_VME = 5;
  // on-board domains held in reset during rst_n; backplane left undriven
  localparam logic [NUM_DOM-1:0] DOM_RESET_N = 6'h20;

  // alternate hot reset also reaches the backplane when set
  localparam logic HOT_TO_BACKPLANE = 1'b1;

endpackage
